// >>> src/csb_defines.vh
// constants for the compare, skip and branch execution unit
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH

// data and address widths
`define CSB_DATA_W 8
`define CSB_PC_W 17
`define CSB_OFS_W 7
`define CSB_OP_W 5

// status flag bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
`define CSB_FLAG_T 6
`define CSB_FLAG_I 7
`define CSB_FLAGS_RESET 8'h00

// operation codes presented by the decoder
`define CSB_OP_NONE 5'h00
`define CSB_OP_CMP_RR 5'h01
`define CSB_OP_CMP_RRC 5'h02
`define CSB_OP_CMP_RI 5'h03
`define CSB_OP_SKIP_REG_CLR 5'h04
`define CSB_OP_SKIP_REG_SET 5'h05
`define CSB_OP_SKIP_IO_CLR 5'h06
`define CSB_OP_SKIP_IO_SET 5'h07
`define CSB_OP_BR_FLAG_SET 5'h08
`define CSB_OP_BR_FLAG_CLR 5'h09
`define CSB_OP_BR_EQ 5'h0A
`define CSB_OP_BR_NE 5'h0B
`define CSB_OP_BR_CS 5'h0C
`define CSB_OP_BR_CC 5'h0D
`define CSB_OP_BR_SH 5'h0E
`define CSB_OP_BR_LO 5'h0F
`define CSB_OP_BR_MI 5'h10
`define CSB_OP_BR_PL 5'h11
`define CSB_OP_BR_GE 5'h12
`define CSB_OP_BR_LT 5'h13

// program counter steps in words
`define CSB_PC_STEP_NEXT 17'h00001
`define CSB_PC_STEP_SKIP1 17'h00002
`define CSB_PC_STEP_SKIP2 17'h00003

// execution cycle counts
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3

`endif

// >>> src/csb_compare_alu.v
// subtract-and-flag datapath for the three compare operations
`timescale 1ns/1ns
`include "csb_defines.vh"

module csb_compare_alu (
	input wire [`CSB_DATA_W-1:0] lhs,
	input wire [`CSB_DATA_W-1:0] rhs,
	input wire use_carry,
	input wire carry_in,
	input wire zero_in,
	output wire carry_out,
	output wire zero_out,
	output wire neg_out,
	output wire ovf_out,
	output wire half_out
);

wire borrow;
wire [`CSB_DATA_W:0] diff;
wire [`CSB_DATA_W-1:0] res;

// difference only; nothing is written back
assign borrow = use_carry & carry_in;
assign diff = {1'b0, lhs} - {1'b0, rhs} - {{`CSB_DATA_W{1'b0}}, borrow};
assign res = diff[`CSB_DATA_W-1:0];

// borrow out of bit 7 and bit 3
assign carry_out = (~lhs[7] & rhs[7]) | (rhs[7] & res[7]) | (res[7] & ~lhs[7]);
assign half_out = (~lhs[3] & rhs[3]) | (rhs[3] & res[3]) | (res[3] & ~lhs[3]);
// two's complement overflow of the subtraction
assign ovf_out = (lhs[7] & ~rhs[7] & ~res[7]) | (~lhs[7] & rhs[7] & res[7]);
assign neg_out = res[7];
// with carry the zero flag only stays set across a chain
assign zero_out = (res == 8'h00) & (~use_carry | zero_in);

endmodule

// >>> src/csb_branch_cond.v
// branch condition evaluation against the status flags
`timescale 1ns/1ns
`include "csb_defines.vh"

module csb_branch_cond (
	input wire [`CSB_OP_W-1:0] op,
	input wire [7:0] flags,
	input wire [2:0] flag_sel,
	output reg is_branch,
	output reg taken
);

wire sel_bit;
wire signed_lt;

assign sel_bit = flags[flag_sel];
assign signed_lt = flags[`CSB_FLAG_N] ^ flags[`CSB_FLAG_V];

// condition per branch form
always @* begin
	is_branch = 1'b1;
	taken = 1'b0;
	case (op)
	`CSB_OP_BR_FLAG_SET: taken = sel_bit; // see [RL7]
	`CSB_OP_BR_FLAG_CLR: taken = ~sel_bit; // see [RL8]
	`CSB_OP_BR_EQ: taken = flags[`CSB_FLAG_Z]; // see [RL9]
	`CSB_OP_BR_NE: taken = ~flags[`CSB_FLAG_Z]; // see [RL10]
	`CSB_OP_BR_CS: taken = flags[`CSB_FLAG_C]; // see [RL11]
	`CSB_OP_BR_LO: taken = flags[`CSB_FLAG_C]; // see [RL11]
	`CSB_OP_BR_CC: taken = ~flags[`CSB_FLAG_C]; // see [RL12]
	`CSB_OP_BR_SH: taken = ~flags[`CSB_FLAG_C]; // see [RL13]
	`CSB_OP_BR_MI: taken = flags[`CSB_FLAG_N]; // see [RL14]
	`CSB_OP_BR_PL: taken = ~flags[`CSB_FLAG_N]; // see [RL15]
	`CSB_OP_BR_GE: taken = ~signed_lt; // see [RL16] see [RL18]
	`CSB_OP_BR_LT: taken = signed_lt; // see [RL16] see [RL18]
	default: begin
		is_branch = 1'b0;
		taken = 1'b0;
	end
	endcase
end

endmodule

// >>> src/csb_unit.v
// compare, skip-if-bit and conditional relative branch execution unit
//
// Functional notes
// [RL1] three compares set Z N V C H, one cycle
// [RL2] register bit clear skips next instruction
// [RL3] register bit set skips next instruction
// [RL4] I/O bit clear skips next instruction
// [RL5] I/O bit set skips next instruction
// [RL6] skips take 1/2/3 cycles, flags untouched
// [RL7] selected flag set: pc plus offset plus one
// [RL8] selected flag clear: pc plus offset plus one
// [RL9] equal branches when zero flag set
// [RL10] not equal branches when zero flag clear
// [RL11] carry set and lower branch on carry
// [RL12] carry clear branches when carry is zero
// [RL13] same or higher branches on carry zero
// [RL14] minus branches when negative flag set
// [RL15] plus branches when negative flag clear
// [RL16] signed less and greater-equal branches exist
// [RL17] branches: 1 or 2 cycles, flags unchanged
// [RL18] signed forms test negative xor overflow
// [RL19] compares never write a general register
`timescale 1ns/1ns
`include "csb_defines.vh"

module csb_unit (
	input wire clk,
	input wire rstn,
	input wire instr_valid,
	input wire [`CSB_OP_W-1:0] instr_op,
	input wire [`CSB_PC_W-1:0] instr_pc,
	input wire [`CSB_DATA_W-1:0] dest_operand,
	input wire [`CSB_DATA_W-1:0] source_operand,
	input wire [`CSB_DATA_W-1:0] immediate,
	input wire [`CSB_DATA_W-1:0] io_data,
	input wire [2:0] bit_sel,
	input wire [`CSB_OFS_W-1:0] branch_offset,
	input wire next_two_word,
	input wire [7:0] status_flags,
	output wire instr_ready,
	output reg done,
	output reg [`CSB_PC_W-1:0] new_pc,
	output reg [7:0] new_status_flags,
	output reg flags_write,
	output reg skip_taken,
	output reg branch_taken,
	output reg bad_op,
	output reg [1:0] cycles_used,
	output wire reg_write_en
);

// timing at a glance
// - one request per rising edge while instr_ready is high
// - one-cycle work: done in the cycle after acceptance
// - taken branch: done two cycles after acceptance
// - taken skip: done two or three cycles after acceptance
// - results stand from acceptance until the next one
// - done and flags_write are single-cycle pulses
// - requests are ignored while a long instruction runs

// one-hot sequencing states
// idle: ready for a new instruction
// wait: counting out the extra cycles of a long one
localparam ST_IDLE = 2'b01;
localparam ST_WAIT = 2'b10;

reg [1:0] state;
reg [1:0] next_state;
reg [1:0] wait_cnt;
reg [1:0] next_wait_cnt;

// decode of the presented operation
wire is_cmp_rr;
wire is_cmp_rrc;
wire is_cmp_ri;
wire is_cmp;
wire is_skip_reg_clr;
wire is_skip_reg_set;
wire is_skip_io_clr;
wire is_skip_io_set;
wire is_skip;
wire is_branch;
wire cond_taken;
wire accept;

assign is_cmp_rr = (instr_op == `CSB_OP_CMP_RR);
assign is_cmp_rrc = (instr_op == `CSB_OP_CMP_RRC);
assign is_cmp_ri = (instr_op == `CSB_OP_CMP_RI);
assign is_cmp = is_cmp_rr | is_cmp_rrc | is_cmp_ri;
assign is_skip_reg_clr = (instr_op == `CSB_OP_SKIP_REG_CLR);
assign is_skip_reg_set = (instr_op == `CSB_OP_SKIP_REG_SET);
assign is_skip_io_clr = (instr_op == `CSB_OP_SKIP_IO_CLR);
assign is_skip_io_set = (instr_op == `CSB_OP_SKIP_IO_SET);
assign is_skip = is_skip_reg_clr | is_skip_reg_set |
	is_skip_io_clr | is_skip_io_set;

// new work only while no multi-cycle instruction is running
// combinational, so back-to-back one-cycle work costs no bubble
assign instr_ready = state[0];
assign accept = instr_valid & instr_ready;

// compare datapath
wire [`CSB_DATA_W-1:0] cmp_rhs;
wire cmp_c;
wire cmp_z;
wire cmp_n;
wire cmp_v;
wire cmp_h;

// immediate form replaces the second register
// the register operand is ignored for the immediate form
assign cmp_rhs = is_cmp_ri ? immediate : source_operand;

// subtractor shared by all three compare forms
// carry input only used by the chained form

csb_compare_alu u_alu (
	.lhs(dest_operand),
	.rhs(cmp_rhs),
	.use_carry(is_cmp_rrc),
	.carry_in(status_flags[`CSB_FLAG_C]),
	.zero_in(status_flags[`CSB_FLAG_Z]),
	.carry_out(cmp_c),
	.zero_out(cmp_z),
	.neg_out(cmp_n),
	.ovf_out(cmp_v),
	.half_out(cmp_h)
);

// flag image after a compare; S and T, I are kept as they were
reg [7:0] cmp_flags;

always @* begin
	cmp_flags = status_flags;
	cmp_flags[`CSB_FLAG_C] = cmp_c; // see [RL1]
	cmp_flags[`CSB_FLAG_Z] = cmp_z; // see [RL1]
	cmp_flags[`CSB_FLAG_N] = cmp_n; // see [RL1]
	cmp_flags[`CSB_FLAG_V] = cmp_v; // see [RL1]
	cmp_flags[`CSB_FLAG_H] = cmp_h; // see [RL1]
end

// compares produce flags only, never a register write
// kept as a port so the register file sees an explicit no-write
assign reg_write_en = 1'b0; // see [RL19]

// skip condition
wire reg_bit;
wire io_bit;
reg skip_cond;

// register skips test the second operand port
// I/O skips test the I/O data port
// both use the same bit index
assign reg_bit = source_operand[bit_sel];
assign io_bit = io_data[bit_sel];

// tested bit against wanted polarity
always @* begin
	skip_cond = 1'b0;
	if (is_skip_reg_clr) begin
		skip_cond = ~reg_bit; // see [RL2]
	end else if (is_skip_reg_set) begin
		skip_cond = reg_bit; // see [RL3]
	end else if (is_skip_io_clr) begin
		skip_cond = ~io_bit; // see [RL4]
	end else if (is_skip_io_set) begin
		skip_cond = io_bit; // see [RL5]
	end
end

// branch condition
// bit_sel doubles as flag index for the generic flag forms
// is_branch low for every code outside the branch group
csb_branch_cond u_cond (
	.op(instr_op),
	.flags(status_flags),
	.flag_sel(bit_sel),
	.is_branch(is_branch),
	.taken(cond_taken)
);

// relative target: sign-extended offset plus one
// wraps modulo the program counter width
// the same adder serves backward and forward branches
wire [`CSB_PC_W-1:0] offset_ext;
wire [`CSB_PC_W-1:0] branch_target;
wire [`CSB_PC_W-1:0] pc_next;
wire [`CSB_PC_W-1:0] pc_skip;

assign offset_ext = {{(`CSB_PC_W-`CSB_OFS_W){branch_offset[`CSB_OFS_W-1]}},
	branch_offset};
// see [RL7] see [RL8]
assign branch_target = instr_pc + offset_ext + `CSB_PC_STEP_NEXT;
assign pc_next = instr_pc + `CSB_PC_STEP_NEXT;
// skipping a two-word instruction needs one more word
assign pc_skip = instr_pc + (next_two_word ? `CSB_PC_STEP_SKIP2 :
	`CSB_PC_STEP_SKIP1); // see [RL2] see [RL3] see [RL4] see [RL5]

// resulting program counter, flags and cycle count per instruction
// priority: compare, then skip, then branch, then unknown
// the classes never overlap, so priority only shapes the logic
// not-taken forms still report pc plus one
reg [`CSB_PC_W-1:0] res_pc;
reg [7:0] res_flags;
reg [1:0] res_cycles;
reg res_flags_write;
reg res_skip;
reg res_branch;
reg res_bad;

always @* begin
	res_pc = pc_next;
	res_flags = status_flags;
	res_cycles = `CSB_CYC_ONE;
	res_flags_write = 1'b0;
	res_skip = 1'b0;
	res_branch = 1'b0;
	res_bad = 1'b0;
	if (is_cmp) begin
		res_flags = cmp_flags;
		res_flags_write = 1'b1;
		res_cycles = `CSB_CYC_ONE; // see [RL1]
	end else if (is_skip) begin
		// flags pass through untouched
		if (skip_cond) begin
			res_pc = pc_skip;
			res_skip = 1'b1;
			res_cycles = next_two_word ? `CSB_CYC_THREE :
				`CSB_CYC_TWO; // see [RL6]
		end else begin
			res_cycles = `CSB_CYC_ONE; // see [RL6]
		end
	end else if (is_branch) begin
		// flags pass through untouched
		if (cond_taken) begin
			res_pc = branch_target;
			res_branch = 1'b1;
			res_cycles = `CSB_CYC_TWO; // see [RL17]
		end else begin
			res_cycles = `CSB_CYC_ONE; // see [RL17]
		end
	end else begin
		// unknown code: step on, flag it, change nothing
		res_bad = (instr_op != `CSB_OP_NONE);
	end
end

// sequencing: one-cycle work stays in idle, longer work waits
// wait_cnt holds the extra cycles still to run
// leaving wait when the count reaches one lines up with done
// stray state codes fall back to idle
always @* begin
	next_state = state;
	next_wait_cnt = wait_cnt;
	case (state)
	ST_IDLE: begin
		if (accept && (res_cycles != `CSB_CYC_ONE)) begin
			next_state = ST_WAIT;
			next_wait_cnt = res_cycles - `CSB_CYC_ONE;
		end
	end
	ST_WAIT: begin
		next_wait_cnt = wait_cnt - `CSB_CYC_ONE;
		if (wait_cnt == `CSB_CYC_ONE) begin
			next_state = ST_IDLE;
		end
	end
	default: begin
		next_state = ST_IDLE;
		next_wait_cnt = 2'h0;
	end
	endcase
end

// state registers
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		state <= ST_IDLE;
		wait_cnt <= 2'h0;
	end else begin
		state <= next_state;
		wait_cnt <= next_wait_cnt;
	end
end

// results are captured at acceptance and held until the next
// for long work they appear before done; consumers wait for done
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		new_pc <= {`CSB_PC_W{1'b0}};
		new_status_flags <= `CSB_FLAGS_RESET;
		skip_taken <= 1'b0;
		branch_taken <= 1'b0;
		bad_op <= 1'b0;
		cycles_used <= 2'h0;
	end else if (accept) begin
		new_pc <= res_pc;
		new_status_flags <= res_flags;
		skip_taken <= res_skip;
		branch_taken <= res_branch;
		bad_op <= res_bad;
		cycles_used <= res_cycles;
	end
end

// completion strobes: flags pulse with done of a compare
// one-cycle work: pulse right after acceptance
// long work: pulse in the cycle after the last wait cycle
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		done <= 1'b0;
		flags_write <= 1'b0;
	end else begin
		done <= 1'b0;
		flags_write <= 1'b0;
		if (accept && (res_cycles == `CSB_CYC_ONE)) begin
			done <= 1'b1;
			flags_write <= res_flags_write; // see [RL1]
		end else if (state[1] && (wait_cnt == `CSB_CYC_ONE)) begin
			done <= 1'b1; // see [RL6] see [RL17]
		end
	end
end

endmodule

// >>> tb/csb_regfile_model.sv
// general register file feeding the unit's operand ports
`timescale 1ns/1ns
module csb_regfile_model (
	input wire clk,
	input wire we,
	input wire [4:0] wsel,
	input wire [7:0] wdata,
	input wire [4:0] rd_sel,
	input wire [4:0] rr_sel,
	output wire [7:0] rd_val,
	output wire [7:0] rr_val
);
reg [7:0] mem [0:31];
// write on the rising edge only
always @(posedge clk) begin
	if (we) mem[wsel] <= wdata;
end
// reads are combinational
assign rd_val = mem[rd_sel];
assign rr_val = mem[rr_sel];
endmodule

// >>> tb/csb_unit_assertions.sv
// concurrent checks on the unit's ports
`timescale 1ns/1ns
module csb_unit_assertions (
	input wire clk,
	input wire rstn,
	input wire instr_valid,
	input wire [4:0] instr_op,
	input wire [16:0] instr_pc,
	input wire [6:0] branch_offset,
	input wire next_two_word,
	input wire [7:0] status_flags,
	input wire instr_ready,
	input wire done,
	input wire [16:0] new_pc,
	input wire [7:0] new_status_flags,
	input wire flags_write,
	input wire skip_taken,
	input wire branch_taken,
	input wire reg_write_en
);
// accepted request and its class
wire acc = instr_valid && instr_ready;
wire cmp = instr_op >= 5'h01 && instr_op <= 5'h03;
wire skp = instr_op[4:2] == 3'h1;
wire br = instr_op >= 5'h08 && instr_op <= 5'h13;
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
no_reg_write_a: assert property (
	!reg_write_en) else $error("register write seen");
cmp_done_a: assert property (
	acc && cmp |=> done && flags_write) else $error("compare late");
skip_flags_a: assert property (
	acc && skp |=> new_status_flags == $past(status_flags))
	else $error("skip changed flags");
br_flags_a: assert property (
	acc && br |=> new_status_flags == $past(status_flags) && !flags_write)
	else $error("branch changed flags");
skip_long_a: assert property (
	acc && skp && next_two_word ##1 skip_taken |->
	(!done && new_pc == $past(instr_pc) + 17'h00003) ##1 !done ##1 done)
	else $error("long skip wrong");
br_target_a: assert property (
	acc && br ##1 branch_taken |-> (!done && new_pc == $past(instr_pc)
	+ {{10{$past(branch_offset[6])}}, $past(branch_offset)} + 17'h00001)
	##1 done) else $error("branch target wrong");
br_equal_a: assert property (
	acc && instr_op == 5'h0A |=> branch_taken == $past(status_flags[1]))
	else $error("equal branch wrong");
br_carry_a: assert property (
	acc && (instr_op == 5'h0C || instr_op == 5'h0F)
	|=> branch_taken == $past(status_flags[0]))
	else $error("carry branch wrong");
br_signed_a: assert property (
	acc && instr_op == 5'h13 |=> branch_taken ==
	($past(status_flags[2]) ^ $past(status_flags[3])))
	else $error("signed branch wrong");
endmodule
bind csb_unit csb_unit_assertions i_csb_unit_assertions (.*);

// >>> tb/csb_unit_tb.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ns
module csb_unit_tb;
reg clk = 1'h0;
reg rstn = 1'h0;
reg instr_valid = 1'h0;
reg next_two_word = 1'h0;
reg we = 1'h0;
reg [4:0] instr_op = 5'h00;
reg [4:0] rd_sel = 5'h05;
reg [4:0] rr_sel = 5'h05;
reg [4:0] wsel = 5'h00;
reg [16:0] instr_pc = 17'h00100;
reg [7:0] immediate = 8'h42;
reg [7:0] io_data = 8'hA5;
reg [7:0] status_flags = 8'h00;
reg [7:0] wdata = 8'h00;
reg [2:0] bit_sel = 3'h0;
reg [6:0] branch_offset = 7'h00;
wire [7:0] dest_operand, source_operand, new_status_flags;
wire instr_ready, done, flags_write, skip_taken, branch_taken;
wire bad_op, reg_write_en;
wire [16:0] new_pc;
wire [1:0] cycles_used;
integer fail_count = 0, num_checks = 0, i, n;
reg t;
reg [16:0] e;
always #10 clk = ~clk;
csb_regfile_model i_csb_regfile_model (.clk(clk), .we(we), .wsel(wsel),
	.wdata(wdata), .rd_sel(rd_sel), .rr_sel(rr_sel),
	.rd_val(dest_operand), .rr_val(source_operand));
csb_unit i_csb_unit (.*);
// compare seen against expected
task chk(input [16:0] seen, input [16:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	end
endtask
task finish_test;
	begin
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	end
endtask
task wr(input [4:0] a, input [7:0] v);
	begin
		we = 1'h1;
		wsel = a;
		wdata = v;
		@(negedge clk);
		we = 1'h0;
	end
endtask
// one instruction; n counts cycles until done
task run(input [4:0] o);
	begin
		instr_op = o;
		instr_valid = 1'h1;
		@(negedge clk);
		instr_valid = 1'h0;
		n = 1;
		if (done !== 1'h1) chk(instr_ready, 1'h0);
		while (done !== 1'h1 && n < 9) begin
			@(negedge clk);
			n = n + 1;
		end
		if (n == 9) begin
			fail_count = fail_count + 1;
			finish_test;
		end
	end
endtask
task cmp(input [4:0] o, input [4:0] d, input [7:0] fi, input [7:0] fe);
	begin
		rd_sel = d;
		status_flags = fi;
		run(o);
		chk(new_status_flags, fe);
		chk(flags_write, 1'h1);
		chk(n[16:0], 17'h00001);
		chk(cycles_used, 17'h00001);
		chk(reg_write_en, 1'h0);
	end
endtask
// branch condition per op code
function tk(input [4:0] o, input [7:0] f, input [2:0] b);
	begin
		case (o)
			5'h08: tk = f[b];
			5'h09: tk = !f[b];
			5'h0A: tk = f[1];
			5'h0B: tk = !f[1];
			5'h0C, 5'h0F: tk = f[0];
			5'h0D, 5'h0E: tk = !f[0];
			5'h10: tk = f[2];
			5'h11: tk = !f[2];
			5'h12: tk = !(f[2] ^ f[3]);
			default: tk = f[2] ^ f[3];
		endcase
	end
endfunction
// main sequence
initial begin
	repeat (12) @(negedge clk);
	rstn = 1'h1;
	chk(new_pc, 17'h00000);
	chk(instr_ready, 1'h1);
	for (i = 1; i < 8; i = i + 1) begin
		wr(i[4:0], 64'h5A05420180201000 >> (8 * i));
	end
	rr_sel = 5'h02;
	cmp(5'h01, 5'h01, 8'hD0, 8'hD5);
	rr_sel = 5'h04;
	cmp(5'h01, 5'h03, 8'h00, 8'h28);
	cmp(5'h03, 5'h05, 8'h00, 8'h02);
	rr_sel = 5'h06;
	cmp(5'h02, 5'h06, 8'h01, 8'h25);
	cmp(5'h02, 5'h06, 8'h00, 8'h00);
	// skips over both operand sources and lengths
	rr_sel = 5'h07;
	status_flags = 8'h3C;
	for (i = 0; i < 32; i = i + 1) begin
		bit_sel = i[4:2];
		next_two_word = i[3] ^ i[0];
		t = i[1] ? io_data[i[4:2]] : source_operand[i[4:2]];
		if (!i[0]) t = !t;
		e = t ? (next_two_word ? 17'h00003 : 17'h00002) : 17'h00001;
		run({3'h1, i[1:0]});
		chk(new_pc, instr_pc + e);
		chk(skip_taken, t);
		chk(n[16:0], e);
		chk(cycles_used, e);
		chk(new_status_flags, status_flags);
	end
	// every branch against four flag patterns
	for (i = 0; i < 48; i = i + 1) begin
		status_flags = 32'h0904FF00 >> (8 * (i / 12));
		bit_sel = i[2:0];
		branch_offset = {i[0], 6'h3F};
		t = tk(5'h08 + i % 12, status_flags, bit_sel);
		e = instr_pc + 17'h00001;
		if (t) e = e + {{10{branch_offset[6]}}, branch_offset};
		run(5'h08 + i % 12);
		chk(new_pc, e);
		chk(branch_taken, t);
		chk(n[16:0], t ? 17'h00002 : 17'h00001);
		chk(cycles_used, t ? 17'h00002 : 17'h00001);
		chk(new_status_flags, status_flags);
	end
	run(5'h1F);
	chk(bad_op, 1'h1);
	chk(new_pc, instr_pc + 17'h00001);
	finish_test;
end
endmodule
